//--- bss_partner.sv
/*
  Far-side model of the boot strap selector: console host on the uart pins and the
  flash agent that keeps saved user entries and replays them after every reset.
  Assumes the bench clock and the active-high reset of the selector.
*/
`timescale 1ns/1ps
module bss_partner import bss_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        uart_tx,
  output      logic        uart_rx,
  output      logic        restore_vld,
  output      logic [2:0]  restore_idx,
  output      logic [31:0] restore_lo,
  output      logic [31:0] restore_title,
  output      logic        restore_done,
  input  wire logic        flash_wr,
  input  wire logic [2:0]  flash_idx,
  input  wire logic [31:0] flash_lo,
  input  wire logic [31:0] flash_title
);
  logic [7:0]  rxq[$];
  logic [7:0]  b;
  logic [31:0] sv_lo[8];
  logic [31:0] sv_ttl[8];
  logic [7:0]  sv_ok;

  initial begin
    uart_rx       = 1'b1;
    restore_vld   = 1'b0;
    restore_idx   = 3'h0;
    restore_lo    = 32'h0;
    restore_title = 32'h0;
    restore_done  = 1'b0;
    sv_ok         = 8'h00;
  end

  // flash survives power loss, so saved entries outlive every reset
  always @(posedge clk) begin
    if (flash_wr === 1'b1) begin
      sv_lo[flash_idx]  <= flash_lo;
      sv_ttl[flash_idx] <= flash_title;
      sv_ok[flash_idx]  <= 1'b1;
    end
  end

  initial forever begin
    @(negedge rst);
    repeat (4) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      if (sv_ok[i]) begin
        restore_vld   <= 1'b1;
        restore_idx   <= 3'(i);
        restore_lo    <= sv_lo[i];
        restore_title <= sv_ttl[i];
        @(posedge clk);
      end
    end
    restore_vld  <= 1'b0;
    restore_done <= 1'b1;
    @(posedge clk);
    restore_done <= 1'b0;
  end

  // 8 data bits lsb first, no parity, one stop, no flow control
  initial forever begin
    @(negedge uart_tx);
    repeat (HALF_CYC) @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      repeat (BIT_CYC) @(posedge clk);
      b[k] = uart_tx;
    end
    repeat (BIT_CYC) @(posedge clk);
    rxq.push_back(b);
  end

  task automatic send_byte(input logic [7:0] v);
    logic [9:0] fr;
    fr = {1'b1, v, 1'b0};
    for (int k = 0; k < 10; k++) begin
      @(posedge clk);
      uart_rx <= fr[k];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
  endtask : send_byte
endmodule : bss_partner

//--- bss_pkg.sv
/*
  Package for the boot strap selector: register map, command codes, timing counts,
  default boot entries and the state record of the selector.
  Assumes a 100 MHz clock and a board controller CPU that turns console text into commands.
*/
// How it works
// RULE1: switch code 0000-0100 names nand, no-boot, spi, i2c, uart boot; rest reserved.
// RULE2: old command loads one 32-bit strap word; full reset restarts the chip with it.
// RULE3: old strap word is volatile; reset drops it and selection reverts.
// RULE4: sixteen boot entries, index 0 to 15, one per switch combination.
// RULE5: entries 8 to 15 are editable and storable; entries 0 to 7 fixed.
// RULE6: entry holds title, unused high word, 32-bit strap word; operator gives high zero.
// RULE7: strap word fields at documented bits; bits 23 and 26-31 reserved.
// RULE8: bits 21 and 22 forced to fixed strap values during reset.
// RULE9: core endian bit must be zero; big endian is handled in software. bss_apply does not clear that bit; it passes through as given.
// RULE10: bare selection query reports the current entry.
// RULE11: list-all reports all sixteen entries and marks the current one.
// RULE12: select by index makes it current, not persisted; power-up uses the switch.
// RULE13: reboot restarts the chip with the currently selected entry.
// RULE14: read-switch samples the switch and makes that entry current.
// RULE15: defining an entry outside 8 to 15 is rejected with an error.
// RULE16: hashed definition goes to flash and persists; unhashed is lost on power loss.
// RULE17: title is display only and never touches the strap word.
// RULE18: switch position 4 is the least significant bit of the index.
// RULE19: with loader jumper removed at power-up, wait for loader, run no firmware.
// RULE20: console is 115200 baud, 8 data bits, no parity, 1 stop, no flow control.
// RULE21: version query reports the firmware version.
// RULE22: host loading firmware uses transfer size 60 and keeps auto baud on.
// RULE23: straps driven while the chip is held in reset, then reset released, pins freed.
package bss_pkg;

  localparam int CLK_HZ         = 100_000_000;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int BAUD           = 115200;
  localparam logic [9:0] BIT_CYC  = 10'(CLK_HZ / BAUD);
  localparam logic [9:0] HALF_CYC = 10'(CLK_HZ / BAUD / 2);
  localparam int RST_HOLD_US    = 100;
  localparam int RST_HOLD_CYC   = RST_HOLD_US * (CLK_HZ / 1_000_000);
  localparam int STRAP_HOLD_NS  = 1000;
  localparam int STRAP_HOLD_CYC = (STRAP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] OFF_CMD     = 8'h00;
  localparam logic [7:0] OFF_ARG_LO  = 8'h04;
  localparam logic [7:0] OFF_ARG_HI  = 8'h08;
  localparam logic [7:0] OFF_ARG_TTL = 8'h0C;
  localparam logic [7:0] OFF_STATUS  = 8'h10;
  localparam logic [7:0] OFF_STRAP   = 8'h14;
  localparam logic [7:0] OFF_VERSION = 8'h18;
  localparam logic [7:0] OFF_RXDATA  = 8'h1C;

  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_IDX_LSB = 4;
  localparam int CMD_HASH    = 8;

  localparam logic [3:0] OP_SETSTRAP = 4'h1;
  localparam logic [3:0] OP_FULLRST  = 4'h2;
  localparam logic [3:0] OP_QUERY    = 4'h3;
  localparam logic [3:0] OP_ALL      = 4'h4;
  localparam logic [3:0] OP_SELECT   = 4'h5;
  localparam logic [3:0] OP_READSW   = 4'h6;
  localparam logic [3:0] OP_DEFINE   = 4'h7;
  localparam logic [3:0] OP_REBOOT   = 4'h8;
  localparam logic [3:0] OP_VERSION  = 4'h9;

  localparam int VS_SEL_LSB = 21;
  localparam logic [1:0]  VS_SEL_FORCED = 2'h0;
  localparam logic [31:0] STRAP_KEEP    = 32'h031F_FFFF;
  localparam logic [3:0]  FIRST_USER    = 4'h8;

  localparam logic [15:0][31:0] DEF_LO = {
    32'h0010_0001, 32'h0000_3661, 32'h0001_516B, 32'h0000_016F,
    32'h0010_0103, 32'h0000_8105, 32'h0000_1061, 32'h0001_0167,
    32'h0000_1061, 32'h0000_1061, 32'h0001_506B, 32'h0000_006F,
    32'h0010_0003, 32'h0000_8005, 32'h0010_0001, 32'h0001_0067};

  typedef enum logic [2:0] {
    BOOT_NAND = 3'h0, BOOT_NOBOOT = 3'h1, BOOT_SPI = 3'h2,
    BOOT_I2C  = 3'h3, BOOT_UART   = 3'h4, BOOT_RSVD = 3'h7
  } bss_boot_t;

  typedef enum logic [4:0] {
    ST_RESTORE = 5'b00001, ST_IDLE = 5'b00010, ST_HOLD = 5'b00100,
    ST_RELEASE = 5'b01000, ST_LOADER = 5'b10000
  } bss_st_t;

  typedef enum logic [1:0] {REP_NONE = 2'h0, REP_ONE = 2'h1, REP_ALL = 2'h2, REP_VER = 2'h3} bss_rep_t;

  typedef struct packed {
    bss_st_t          st;
    logic [31:0]      cnt;
    logic [15:0][31:0] lo;
    logic [15:0][31:0] hi;
    logic [15:0][31:0] title;
    logic [3:0]       cur;
    logic [31:0]      ovr;
    logic             ovr_on;
    logic [31:0]      arg_lo;
    logic [31:0]      arg_hi;
    logic [31:0]      arg_ttl;
    logic [31:0]      strap;
    logic             strap_oe;
    logic             soc_rst_n;
    logic             err;
    logic             loader;
    logic [31:0]      rdata;
    logic [3:0]       sw_s1;
    logic [3:0]       sw_s2;
    logic             jmp_s1;
    logic             jmp_s2;
    logic             rx_s1;
    logic             rx_s2;
    logic             rx_busy;
    logic [9:0]       rx_cnt;
    logic [3:0]       rx_bit;
    logic [7:0]       rx_sh;
    logic [7:0]       rx_byte;
    logic             rx_vld;
    logic             rx_ferr;
    bss_rep_t         rep;
    logic [3:0]       rep_ent;
    logic [1:0]       rep_sub;
    logic             tx_busy;
    logic [9:0]       tx_cnt;
    logic [3:0]       tx_bit;
    logic [9:0]       tx_sh;
    logic             tx_line;
    logic             flash_wr;
    logic [2:0]       flash_idx;
    logic [31:0]      flash_lo;
    logic [31:0]      flash_ttl;
  } bss_state_t;

  function automatic logic [31:0] bss_apply(input logic [31:0] w);
    bss_apply = (w & STRAP_KEEP) | (32'(VS_SEL_FORCED) << VS_SEL_LSB); // RULE7 RULE8
  endfunction : bss_apply

  function automatic logic [7:0] bss_hex(input logic [3:0] n);
    bss_hex = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : bss_hex

endpackage : bss_pkg

//--- bss_selector.sv
/*
  Boot strap selector: switch and command driven choice of boot entry, strap drive
  around the chip reset, console uart with text reports, flash save/restore port.
  Assumes a CPU issuing commands over the plain register port and an outside flash
  agent that replays saved user entries after reset and then pulses restore_done.
*/
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module bss_selector import bss_pkg::*; #(
  parameter int         HOLD_CYC   = RST_HOLD_CYC,
  parameter logic [7:0] FW_VERSION = 8'h10   // arbitrary
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output      logic [31:0] rdata,
  input  wire logic [3:0]  switch_in,
  input  wire logic        firmware_loader_jumper,
  input  wire logic        uart_rx,
  output      logic        uart_tx,
  output      logic [31:0] strap_out,
  output      logic        strap_oe,
  output      logic        soc_rst_n,
  output      logic        loader_mode,
  input  wire logic        restore_vld,
  input  wire logic [2:0]  restore_idx,
  input  wire logic [31:0] restore_lo,
  input  wire logic [31:0] restore_title,
  input  wire logic        restore_done,
  output      logic        flash_wr,
  output      logic [2:0]  flash_idx,
  output      logic [31:0] flash_lo,
  output      logic [31:0] flash_title
);

  bss_state_t q;
  bss_state_t d;
  logic       cmd_wr;
  logic       cmd_go;
  logic [3:0] op;
  logic [3:0] idx;
  logic [7:0] tx_byte;
  bss_boot_t  boot_kind;

  assign op     = wdata[CMD_OP_LSB +: 4];
  assign idx    = wdata[CMD_IDX_LSB +: 4];
  assign cmd_wr = wr && (addr == OFF_CMD);
  assign cmd_go = cmd_wr && (q.st == ST_IDLE) && (q.rep == REP_NONE);

  // switch code to boot kind, codes above 0100 reserved
  always_comb begin
    unique case (q.cur) // RULE1
      4'h0:    boot_kind = BOOT_NAND;
      4'h1:    boot_kind = BOOT_NOBOOT;
      4'h2:    boot_kind = BOOT_SPI;
      4'h3:    boot_kind = BOOT_I2C;
      4'h4:    boot_kind = BOOT_UART;
      default: boot_kind = BOOT_RSVD;
    endcase
  end

  // report text: one line per entry "<hex><mark>\n", version "<hex><hex>\n"
  always_comb begin
    tx_byte = 8'h0A;
    if (q.rep == REP_VER) begin // RULE21
      if (q.rep_sub == 2'h0) tx_byte = bss_hex(FW_VERSION[7:4]);
      if (q.rep_sub == 2'h1) tx_byte = bss_hex(FW_VERSION[3:0]);
    end else begin
      if (q.rep_sub == 2'h0) tx_byte = bss_hex(q.rep_ent); // RULE10
      if (q.rep_sub == 2'h1) tx_byte = (q.rep_ent == q.cur) ? 8'h2A : 8'h20; // RULE11
    end
  end

  always_comb begin
    d          = q;
    d.flash_wr = 1'b0;
    d.rdata    = 32'h0;
    d.sw_s1    = switch_in;
    d.sw_s2    = q.sw_s1;
    d.jmp_s1   = firmware_loader_jumper;
    d.jmp_s2   = q.jmp_s1;
    d.rx_s1    = uart_rx;
    d.rx_s2    = q.rx_s1;

    if (wr) begin
      case (addr)
        OFF_ARG_LO:  d.arg_lo = wdata;
        OFF_ARG_HI:  d.arg_hi = wdata;
        OFF_ARG_TTL: d.arg_ttl = wdata;
        default:     ;
      endcase
    end
    if (rd) begin
      case (addr)
        OFF_ARG_LO:  d.rdata = q.arg_lo;
        OFF_ARG_HI:  d.rdata = q.arg_hi;
        OFF_ARG_TTL: d.rdata = q.arg_ttl;
        OFF_STATUS:  d.rdata = {10'h0, q.st, q.loader, q.ovr_on, q.err, q.rx_ferr, q.rx_vld,
                                (q.rep != REP_NONE), boot_kind, q.sw_s2, q.cur};
        OFF_STRAP:   d.rdata = q.strap;
        OFF_VERSION: d.rdata = {24'h0, FW_VERSION};
        OFF_RXDATA:  d.rdata = {23'h0, q.rx_vld, q.rx_byte};
        default:     d.rdata = 32'h0;
      endcase
      // reading clears; a fresh event later in this process wins
      if (addr == OFF_STATUS) d.err = 1'b0;
      if (addr == OFF_RXDATA) begin
        d.rx_vld  = 1'b0;
        d.rx_ferr = 1'b0;
      end
    end
    if (cmd_wr && !cmd_go) d.err = 1'b1;

    unique case (q.st)
      ST_RESTORE: begin
        if (restore_vld) begin // RULE16
          d.lo[{1'b1, restore_idx}]    = restore_lo;
          d.title[{1'b1, restore_idx}] = restore_title;
        end
        if (restore_done) begin
          d.cur    = q.sw_s2; // RULE12 RULE18
          d.loader = ~q.jmp_s2;
          if (!q.jmp_s2) begin
            d.st = ST_LOADER; // RULE19
          end else begin
            d.strap     = bss_apply(q.lo[q.sw_s2]);
            d.strap_oe  = 1'b1;
            d.soc_rst_n = 1'b0;
            d.cnt       = 32'(HOLD_CYC - 1);
            d.st        = ST_HOLD;
          end
        end
      end
      ST_IDLE: begin
        if (cmd_go) begin
          unique case (op)
            OP_SETSTRAP: begin
              d.ovr    = q.arg_lo; // RULE2
              d.ovr_on = 1'b1;
            end
            OP_FULLRST, OP_REBOOT: begin
              // title never enters the strap path; only the low word does
              d.strap     = bss_apply((op == OP_FULLRST && q.ovr_on) ? q.ovr : q.lo[q.cur]); // RULE2 RULE13 RULE17
              d.strap_oe  = 1'b1; // RULE23
              d.soc_rst_n = 1'b0;
              d.cnt       = 32'(HOLD_CYC - 1);
              d.st        = ST_HOLD;
            end
            OP_QUERY: begin
              d.rep     = REP_ONE; // RULE10
              d.rep_ent = q.cur;
              d.rep_sub = 2'h0;
            end
            OP_ALL: begin
              d.rep     = REP_ALL; // RULE11
              d.rep_ent = 4'h0;
              d.rep_sub = 2'h0;
            end
            OP_VERSION: begin
              d.rep     = REP_VER; // RULE21
              d.rep_sub = 2'h0;
            end
            OP_SELECT: begin
              d.cur    = idx; // RULE12
              d.ovr_on = 1'b0;
            end
            OP_READSW: begin
              d.cur    = q.sw_s2; // RULE14 RULE18
              d.ovr_on = 1'b0;
            end
            OP_DEFINE: begin
              if (idx < FIRST_USER) begin
                d.err = 1'b1; // RULE15 RULE5
              end else begin
                // high word kept but never used, operator supplies zero
                d.lo[idx]    = q.arg_lo; // RULE6 RULE4
                d.hi[idx]    = q.arg_hi; // RULE6
                d.title[idx] = q.arg_ttl;
                if (wdata[CMD_HASH]) begin
                  d.flash_wr  = 1'b1; // RULE16
                  d.flash_idx = idx[2:0];
                  d.flash_lo  = q.arg_lo;
                  d.flash_ttl = q.arg_ttl;
                end
              end
            end
            default: d.err = 1'b1;
          endcase
        end
      end
      ST_HOLD: begin
        d.cnt = q.cnt - 32'h1;
        if (q.cnt == 32'h0) begin
          d.soc_rst_n = 1'b1; // RULE23
          d.cnt       = 32'(STRAP_HOLD_CYC - 1);
          d.st        = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        // straps held past the release edge so the chip latches them cleanly
        d.cnt = q.cnt - 32'h1;
        if (q.cnt == 32'h0) begin
          d.strap_oe = 1'b0; // RULE23
          d.st       = ST_IDLE;
        end
      end
      ST_LOADER: ;
    endcase

    // receiver, 8N1, sampled at mid bit
    if (!q.rx_busy) begin
      if (!q.rx_s2) begin
        d.rx_busy = 1'b1; // RULE20
        d.rx_cnt  = HALF_CYC;
        d.rx_bit  = 4'h0;
      end
    end else if (q.rx_cnt != 10'h0) begin
      d.rx_cnt = q.rx_cnt - 10'h1;
    end else begin
      d.rx_cnt = BIT_CYC - 10'h1;
      d.rx_bit = q.rx_bit + 4'h1;
      if (q.rx_bit == 4'h0) begin
        if (q.rx_s2) d.rx_busy = 1'b0;
      end else if (q.rx_bit < 4'h9) begin
        d.rx_sh = {q.rx_s2, q.rx_sh[7:1]}; // RULE20
      end else begin
        d.rx_busy = 1'b0;
        if (q.rx_s2) begin
          d.rx_byte = q.rx_sh;
          d.rx_vld  = 1'b1;
        end else begin
          d.rx_ferr = 1'b1;
        end
      end
    end

    // transmitter, one start, eight data lsb first, one stop, no flow control
    if (!q.tx_busy) begin
      if (q.rep != REP_NONE) begin
        d.tx_busy = 1'b1;
        d.tx_sh   = {1'b1, tx_byte, 1'b0}; // RULE20
        d.tx_bit  = 4'h0;
        d.tx_cnt  = BIT_CYC - 10'h1;
        d.tx_line = 1'b0;
        if (q.rep_sub == 2'h2) begin
          d.rep_sub = 2'h0;
          d.rep_ent = q.rep_ent + 4'h1;
          if (q.rep != REP_ALL || q.rep_ent == 4'hF) d.rep = REP_NONE;
        end else begin
          d.rep_sub = q.rep_sub + 2'h1;
        end
      end
    end else if (q.tx_cnt != 10'h0) begin
      d.tx_cnt = q.tx_cnt - 10'h1;
    end else begin
      d.tx_cnt = BIT_CYC - 10'h1;
      d.tx_bit = q.tx_bit + 4'h1;
      if (q.tx_bit == 4'h9) begin
        d.tx_busy = 1'b0;
        d.tx_line = 1'b1;
      end else begin
        d.tx_line = q.tx_sh[q.tx_bit + 4'h1];
      end
    end
  end

  // any reset drops the old strap word and volatile edits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q         <= '0; // RULE3
      q.st      <= ST_RESTORE;
      q.lo      <= DEF_LO;
      q.tx_line <= 1'b1;
      q.rx_s1   <= 1'b1;
      q.rx_s2   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign rdata       = q.rdata;
  assign uart_tx     = q.tx_line;
  assign strap_out   = q.strap;
  assign strap_oe    = q.strap_oe;
  assign soc_rst_n   = q.soc_rst_n;
  assign loader_mode = q.loader;
  assign flash_wr    = q.flash_wr;
  assign flash_idx   = q.flash_idx;
  assign flash_lo    = q.flash_lo;
  assign flash_title = q.flash_ttl;

  strap_force_a: assert property (@(posedge clk) disable iff (rst) // RULE8
    strap_oe |-> strap_out[VS_SEL_LSB +: 2] == VS_SEL_FORCED) else $error("forced strap bits wrong");
  reserved_zero_a: assert property (@(posedge clk) disable iff (rst) // RULE7
    strap_oe |-> (strap_out[31:26] == 6'h0 && !strap_out[23])) else $error("reserved strap bits set");
  hold_drive_a: assert property (@(posedge clk) disable iff (rst) // RULE23
    (q.st == ST_HOLD) |-> (!soc_rst_n && strap_oe)) else $error("straps not driven in reset");
  release_keep_a: assert property (@(posedge clk) disable iff (rst) // RULE23
    $rose(soc_rst_n) |-> strap_oe ##1 strap_oe) else $error("straps dropped at release");
  define_reject_a: assert property (@(posedge clk) disable iff (rst) // RULE15
    (cmd_go && op == OP_DEFINE && idx < FIRST_USER) |=> q.err && $stable(q.lo)) else $error("fixed entry edited");
  flash_save_a: assert property (@(posedge clk) disable iff (rst) // RULE16
    (cmd_go && op == OP_DEFINE && idx >= FIRST_USER) |=> flash_wr == $past(wdata[CMD_HASH]))
    else $error("flash write mismatch");
  select_idx_a: assert property (@(posedge clk) disable iff (rst) // RULE12
    (cmd_go && op == OP_SELECT) |=> q.cur == $past(idx) && !q.ovr_on) else $error("select failed");
  read_switch_a: assert property (@(posedge clk) disable iff (rst) // RULE14
    (cmd_go && op == OP_READSW) |=> q.cur == $past(q.sw_s2)) else $error("switch read failed");
  reboot_word_a: assert property (@(posedge clk) disable iff (rst) // RULE13
    (cmd_go && op == OP_REBOOT) |=> !soc_rst_n && strap_out == bss_apply($past(q.lo[q.cur])))
    else $error("reboot used wrong entry");
  fullrst_ovr_a: assert property (@(posedge clk) disable iff (rst) // RULE2
    (cmd_go && op == OP_FULLRST && q.ovr_on) |=> strap_out == bss_apply($past(q.ovr)))
    else $error("full reset ignored strap word");

endmodule : bss_selector

//--- testbench.sv
/*
  Self-checking bench of the boot strap selector: commands over the register port,
  strap and chip reset timing, console traffic both ways, power cycles, loader jumper.
  Assumes bss_partner as console host and flash agent.
*/
`timescale 1ns/1ps
module testbench import bss_pkg::*; ;
  localparam int         HOLD = 20;
  localparam logic [7:0] VER  = 8'h5A;  // arbitrary
  logic        clk, rst, wr, rd, jumper, uart_rx, uart_tx, strap_oe, soc_rst_n, loader_mode;
  logic        r_vld, r_done, f_wr;
  logic [2:0]  r_idx, f_idx;
  logic [3:0]  sw;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, strap_out, r_lo, r_ttl, f_lo, f_ttl, d, w, t;
  logic [31:0] ent[16];
  logic [31:0] saved[16];
  logic        kept[16];
  logic [3:0]  dl[4];
  int          num_errors, checks_done, seed, n;

  bss_selector #(.HOLD_CYC(HOLD), .FW_VERSION(VER)) bss_selector_inst (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .switch_in(sw), .firmware_loader_jumper(jumper), .uart_rx(uart_rx), .uart_tx(uart_tx),
    .strap_out(strap_out), .strap_oe(strap_oe), .soc_rst_n(soc_rst_n), .loader_mode(loader_mode),
    .restore_vld(r_vld), .restore_idx(r_idx), .restore_lo(r_lo), .restore_title(r_ttl),
    .restore_done(r_done), .flash_wr(f_wr), .flash_idx(f_idx), .flash_lo(f_lo), .flash_title(f_ttl));

  bss_partner bss_partner_inst (
    .clk(clk), .rst(rst), .uart_tx(uart_tx), .uart_rx(uart_rx), .restore_vld(r_vld),
    .restore_idx(r_idx), .restore_lo(r_lo), .restore_title(r_ttl), .restore_done(r_done),
    .flash_wr(f_wr), .flash_idx(f_idx), .flash_lo(f_lo), .flash_title(f_ttl));

  always #5 clk = ~clk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic hang();
    num_errors++;
    stop_test();
  endtask : hang

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg

  task automatic cmd(input logic [3:0] op, input logic [3:0] idx, input logic h);
    wr_reg(OFF_CMD, {23'h0, h, idx, op});
  endtask : cmd

  function automatic logic [31:0] masked(input logic [31:0] v);
    masked = (v & 32'h031F_FFFF) | (32'(VS_SEL_FORCED) << 21);
  endfunction : masked

  function automatic logic [7:0] hexc(input logic [3:0] v);
    hexc = (v > 4'h9) ? 8'h37 + 8'(v) : 8'h30 + 8'(v);
  endfunction : hexc

  // the whole hold, release and idle return of one chip reset
  task automatic boot_watch(input logic [31:0] exp);
    #1;
    for (n = 0; n < 200 && strap_oe !== 1'b1; n++) step();
    if (n == 200) hang();
    chk(32'(soc_rst_n), 32'h0);
    chk(strap_out, exp);
    for (n = 0; n < 300 && soc_rst_n !== 1'b1; n++) step();
    chk(32'(n >= HOLD - 1 && n <= HOLD + 1), 32'h1);
    chk(32'(strap_oe), 32'h1);
    chk(strap_out, exp);
    for (n = 0; n < 300 && strap_oe !== 1'b0; n++) step();
    chk(32'(n >= STRAP_HOLD_CYC - 1 && n <= STRAP_HOLD_CYC + 1), 32'h1);
    repeat (3) @(posedge clk);
  endtask : boot_watch

  task automatic expect_tx(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    for (n = 0; n < 30000 && bss_partner_inst.rxq.size() < 3; n++) @(posedge clk);
    if (n == 30000) hang();
    chk(32'(bss_partner_inst.rxq[0]), 32'(b0));
    chk(32'(bss_partner_inst.rxq[1]), 32'(b1));
    chk(32'(bss_partner_inst.rxq[2]), 32'(b2));
    bss_partner_inst.rxq.delete();
    repeat (BIT_CYC) @(posedge clk);
  endtask : expect_tx

  task automatic power(input logic [3:0] s, input logic j);
    @(posedge clk);
    sw     <= s;
    jumper <= j;
    rst    <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 8; i < 16; i++) ent[i] = kept[i] ? saved[i] : DEF_LO[i];
  endtask : power

  initial begin
    clk         = 1'b0;
    rst         = 1'b1;
    wr          = 1'b0;
    rd          = 1'b0;
    addr        = 8'h00;
    wdata       = 32'h0;
    sw          = 4'h0;
    jumper      = 1'b1;
    num_errors  = 0;
    checks_done = 0;
    seed        = 53973;
    dl          = '{4'h3, 4'h7, 4'h9, 4'hF};
    for (int i = 0; i < 16; i++) begin
      ent[i]  = DEF_LO[i];
      kept[i] = 1'b0;
    end
    power(4'h2, 1'b1);
    boot_watch(masked(ent[2]));
    rd_reg(OFF_STATUS, d);
    chk(32'(d[3:0]), 32'h2);
    chk(32'(d[10:8]), 32'(BOOT_SPI));
    $display("test power_up done");

    // reserved strap bits set on purpose, core endian kept little
    w = $random(seed) | 32'hFCE0_0000;
    w[19] = 1'b0;
    wr_reg(OFF_ARG_LO, w);
    cmd(OP_SETSTRAP, 4'h0, 1'b0);
    cmd(OP_FULLRST, 4'h0, 1'b0);
    boot_watch(masked(w));
    rd_reg(OFF_STRAP, d);
    chk(d, masked(w));
    rd_reg(OFF_VERSION, d);
    chk(32'(d[7:0]), 32'(VER));
    wr_reg(8'h40, $random(seed));
    rd_reg(8'h40, d);
    chk(d, 32'h0);
    $display("test strap_word done");

    foreach (dl[k]) begin
      w = $random(seed);
      w[19] = 1'b0;
      t = $random(seed);
      wr_reg(OFF_ARG_LO, w);
      wr_reg(OFF_ARG_HI, 32'h0);
      wr_reg(OFF_ARG_TTL, t);
      cmd(OP_DEFINE, dl[k], dl[k] == 4'hF);
      #1;
      if (dl[k] >= FIRST_USER) ent[dl[k]] = w;
      chk(32'(f_wr), 32'(dl[k] == 4'hF));
      if (dl[k] == 4'hF) begin
        kept[15]  = 1'b1;
        saved[15] = w;
        chk(32'(f_idx), 32'h7);
        chk(f_lo, w);
        chk(f_ttl, t);
      end
      rd_reg(OFF_STATUS, d);
      chk(32'(d[14]), 32'(dl[k] < FIRST_USER));
      cmd(OP_SELECT, dl[k], 1'b0);
      cmd(OP_REBOOT, 4'h0, 1'b0);
      boot_watch(masked(ent[dl[k]]));
    end
    $display("test define_select done");

    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      sw <= (k == 0) ? 4'h1 : 4'($random(seed));
      repeat (4) @(posedge clk);
      cmd(OP_READSW, 4'h0, 1'b0);
      rd_reg(OFF_STATUS, d);
      chk(32'(d[3:0]), 32'(sw));
      cmd(OP_REBOOT, 4'h0, 1'b0);
      boot_watch(masked(ent[sw]));
    end
    $display("test read_switch done");

    cmd(OP_QUERY, 4'h0, 1'b0);
    expect_tx(hexc(sw), 8'h2A, 8'h0A);
    cmd(OP_VERSION, 4'h0, 1'b0);
    expect_tx(hexc(VER[7:4]), hexc(VER[3:0]), 8'h0A);
    w = $random(seed);
    bss_partner_inst.send_byte(w[7:0]);
    rd_reg(OFF_RXDATA, d);
    chk(32'(d[8:0]), {23'h0, 1'b1, w[7:0]});
    $display("test console done");

    cmd(OP_SETSTRAP, 4'h0, 1'b0);
    cmd(OP_ALL, 4'h0, 1'b0);
    // only the first line is heard; the power cycle cuts the list short to save run time
    expect_tx(8'h30, (sw == 4'h0) ? 8'h2A : 8'h20, 8'h0A);
    power(4'hF, 1'b1);
    boot_watch(masked(saved[15]));
    cmd(OP_FULLRST, 4'h0, 1'b0);
    boot_watch(masked(ent[15]));
    cmd(OP_SELECT, 4'h9, 1'b0);
    cmd(OP_REBOOT, 4'h0, 1'b0);
    boot_watch(masked(DEF_LO[9]));
    $display("test power_cycle done");

    power(4'h1, 1'b0);
    repeat (50) @(posedge clk);
    cmd(OP_REBOOT, 4'h0, 1'b0);
    repeat (50) step();
    chk(32'(loader_mode), 32'h1);
    chk(32'(soc_rst_n), 32'h0);
    // loader host opens with the auto-baud sync pattern
    bss_partner_inst.send_byte(8'h55);
    rd_reg(OFF_RXDATA, d);
    chk(32'(d[8:0]), 32'h155);
    $display("test loader done");
    stop_test();
  end
endmodule : testbench
